// ### design/sram_host_ctrl.sv
// Host controller that drives a 256x4 asynchronous static RAM through its pins.
// Assumes the RAM sits on the pins named below and that requests come from
// logic on the same clock.
//
// Overview of operation
// - Idle: low select high, all inputs held still.
// - Shared bus: tie lines, output_off keeps outputs off.
// - Both selects held 550 ns before write end.
// - High select low before lowering supply.
// - Stay deselected one read cycle after supply returns.
// - Separate lines: output_off may stay low.
// - Shared bus: output_off high during writes.
`timescale 1ns/100ps
`default_nettype none
`include "sram_host_regs.svh"

module sram_host_ctrl #(
    parameter int ADDR_W    = `SRAM_ADDR_W,
    parameter int DATA_W    = `SRAM_DATA_W,
    parameter bit SHARED_IO = 1'b0
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata,
    input  wire logic              retain_req,
    output logic                   retain_ready,
    output logic      [ADDR_W-1:0] word_address,
    output logic                   select_low_active_n,
    output logic                   select_high_active,
    output logic                   read_write,
    output logic                   output_off,
    output logic      [DATA_W-1:0] write_data_lines,
    output logic                   write_data_oe,
    input  wire logic [DATA_W-1:0] read_data_lines
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_int_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_int_n = rst_s2_q;

    // ------------------------------------------------------------------
    // Read data synchroniser
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rd_s2;
    logic [DATA_W-1:0] rd_s3;

    sram_pin_sync #(
        .W (DATA_W)
    ) u_rd_sync (
        .clock  (clock),
        .rst_n  (rst_int_n),
        .pin    (read_data_lines),
        .stage2 (rd_s2),
        .stage3 (rd_s3)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    localparam logic [7:0] RC_CYC   = 8'(`SRAM_RC_CYC);
    // Waiting for the slowest of address, select and enable access also
    // covers the synchroniser delay.
    localparam logic [7:0] RD_CYC   = 8'(`SRAM_A_CYC + `SRAM_SYNC_CYC);
    localparam logic [7:0] TURN_CYC = 8'(`SRAM_DF_CYC > `SRAM_DS_CYC ?
                                         `SRAM_DF_CYC : `SRAM_DS_CYC);
    localparam logic [7:0] AW_CYC   = 8'(`SRAM_AW_CYC);
    // The pulse is stretched so that both selects stand long enough before its end.
    localparam logic [7:0] WP_CYC   = 8'((`SRAM_WP_CYC > `SRAM_CW_CYC - `SRAM_AW_CYC) ?
                                         `SRAM_WP_CYC : `SRAM_CW_CYC - `SRAM_AW_CYC);
    localparam logic [7:0] HOLD_CYC = 8'((`SRAM_DH_CYC > `SRAM_WR_CYC) ?
                                         `SRAM_DH_CYC : `SRAM_WR_CYC);

    sram_host_pkg::state_t state_q;
    sram_host_pkg::state_t state_d;
    logic [7:0]            cnt_q;
    logic [7:0]            cnt_d;
    sram_host_pkg::pins_t  pins_q;
    sram_host_pkg::pins_t  pins_d;
    sram_host_pkg::req_t   req_q;
    sram_host_pkg::req_t   req_d;
    logic                  rsp_valid_q;
    logic                  rsp_valid_d;
    logic [DATA_W-1:0]     rdata_q;
    logic [DATA_W-1:0]     rdata_d;
    logic                  cnt_done;
    logic                  idle_off;

    assign cnt_done  = (cnt_q == 8'h00);
    assign idle_off  = SHARED_IO ? 1'b1 : 1'b0;
    assign req_ready = (state_q == sram_host_pkg::ST_IDLE) && !retain_req;

    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_done ? cnt_q : cnt_q - 8'h01;
        pins_d      = pins_q;
        req_d       = req_q;
        rsp_valid_d = 1'b0;
        rdata_d     = rdata_q;
        unique case (state_q)
            sram_host_pkg::ST_IDLE: begin
                // Deselected with every input still; the address is left where it was.
                pins_d.select_low_active_n = 1'b1;
                pins_d.select_high_active  = 1'b1;
                pins_d.read_write          = 1'b1;
                pins_d.output_off          = idle_off;
                pins_d.write_data_oe       = !SHARED_IO;
                if (retain_req) begin
                    pins_d.select_high_active = 1'b0;
                    state_d                   = sram_host_pkg::ST_RETAIN;
                end else if (req_valid) begin
                    req_d.write              = req_write;
                    req_d.addr               = req_addr;
                    req_d.wdata              = req_wdata;
                    pins_d.word_address      = req_addr;
                    pins_d.select_low_active_n = 1'b0;
                    if (req_write) begin
                        pins_d.write_data_lines = req_wdata;
                        pins_d.write_data_oe    = 1'b1;
                        pins_d.output_off       = SHARED_IO ? 1'b1 : idle_off;
                        cnt_d                   = AW_CYC - 8'h01;
                        state_d                 = sram_host_pkg::ST_WR_SETUP;
                    end else begin
                        pins_d.read_write = 1'b1;
                        pins_d.output_off = 1'b0;
                        cnt_d             = RD_CYC - 8'h01;
                        state_d           = sram_host_pkg::ST_RD_ACCESS;
                    end
                end
            end
            sram_host_pkg::ST_RD_ACCESS: begin
                // Sample only once the last two stages agree, and before deselecting.
                if (cnt_done && (rd_s2 == rd_s3)) begin
                    rdata_d                    = rd_s3;
                    rsp_valid_d                = 1'b1;
                    pins_d.select_low_active_n = 1'b1;
                    pins_d.output_off          = idle_off;
                    cnt_d                      = TURN_CYC - 8'h01;
                    state_d                    = sram_host_pkg::ST_TURN;
                end
            end
            sram_host_pkg::ST_TURN: begin
                // Give the outputs time to float before anything else drives the lines.
                if (cnt_done) begin
                    state_d = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_WR_SETUP: begin
                if (cnt_done) begin
                    pins_d.read_write = 1'b0;
                    cnt_d             = WP_CYC - 8'h01;
                    state_d           = sram_host_pkg::ST_WR_PULSE;
                end
            end
            sram_host_pkg::ST_WR_PULSE: begin
                // Data stays put through the rising edge, where the RAM captures it.
                if (cnt_done) begin
                    pins_d.read_write = 1'b1;
                    cnt_d             = HOLD_CYC - 8'h01;
                    state_d           = sram_host_pkg::ST_WR_HOLD;
                end
            end
            sram_host_pkg::ST_WR_HOLD: begin
                if (cnt_done) begin
                    pins_d.select_low_active_n = 1'b1;
                    pins_d.write_data_oe       = !SHARED_IO;
                    pins_d.output_off          = idle_off;
                    rsp_valid_d                = 1'b1;
                    state_d                    = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_RETAIN: begin
                if (!retain_req) begin
                    cnt_d   = RC_CYC - 8'h01;
                    state_d = sram_host_pkg::ST_RESUME;
                end
            end
            sram_host_pkg::ST_RESUME: begin
                // The high select stays low for a full read cycle after power returns.
                if (retain_req) begin
                    state_d = sram_host_pkg::ST_RETAIN;
                end else if (cnt_done) begin
                    pins_d.select_high_active = 1'b1;
                    state_d                   = sram_host_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_q     <= sram_host_pkg::ST_RESUME;
            cnt_q       <= 8'(`SRAM_RC_CYC - 1);
            pins_q      <= '{word_address: '0, select_low_active_n: 1'b1,
                             select_high_active: 1'b0, read_write: 1'b1,
                             output_off: 1'b1, write_data_lines: '0,
                             write_data_oe: 1'b0};
            req_q       <= '0;
            rsp_valid_q <= 1'b0;
            rdata_q     <= '0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            pins_q      <= pins_d;
            req_q       <= req_d;
            rsp_valid_q <= rsp_valid_d;
            rdata_q     <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign word_address        = pins_q.word_address;
    assign select_low_active_n = pins_q.select_low_active_n;
    assign select_high_active  = pins_q.select_high_active;
    assign read_write          = pins_q.read_write;
    assign output_off          = pins_q.output_off;
    assign write_data_lines    = pins_q.write_data_lines;
    assign write_data_oe       = pins_q.write_data_oe;
    assign rsp_valid           = rsp_valid_q;
    assign rsp_rdata           = rdata_q;
    assign retain_ready        = (state_q == sram_host_pkg::ST_RETAIN);

endmodule

`default_nettype wire

// ### design/sram_host_pkg.sv
// Types shared by the static RAM host controller.
// Assumes sram_host_regs.svh is compiled alongside it.
`include "sram_host_regs.svh"

package sram_host_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ACCESS,
        ST_TURN,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_RETAIN,
        ST_RESUME
    } state_t;

    typedef struct packed {
        logic [`SRAM_ADDR_W-1:0] word_address;
        logic                    select_low_active_n;
        logic                    select_high_active;
        logic                    read_write;
        logic                    output_off;
        logic [`SRAM_DATA_W-1:0] write_data_lines;
        logic                    write_data_oe;
    } pins_t;

    typedef struct packed {
        logic                    write;
        logic [`SRAM_ADDR_W-1:0] addr;
        logic [`SRAM_DATA_W-1:0] wdata;
    } req_t;

endpackage

// ### design/sram_host_regs.svh
// Timing constants for the host that drives the 256x4 static RAM.
// Assumes the host clock runs at 125 MHz; every cycle count except SRAM_SYNC_CYC is derived from it.
`ifndef SRAM_HOST_REGS_SVH
`define SRAM_HOST_REGS_SVH

`define SRAM_CLK_PERIOD_NS 8
`define SRAM_ADDR_W        8
`define SRAM_DATA_W        4

// ----------------------------------------------------------------------
// Minimum and maximum times of the standard grade, in ns
// ----------------------------------------------------------------------
`define SRAM_T_RC_NS  650
`define SRAM_T_A_NS   650
`define SRAM_T_DF_NS  150
`define SRAM_T_AW_NS  150
`define SRAM_T_WP_NS  400
`define SRAM_T_CW_NS  550
`define SRAM_T_DH_NS  100
`define SRAM_T_WR_NS  50
`define SRAM_T_DS_NS  150

// ----------------------------------------------------------------------
// Cycle counts, rounded up so that every wait covers the full time
// ----------------------------------------------------------------------
`define SRAM_CYC(t) (((t) + `SRAM_CLK_PERIOD_NS - 1) / `SRAM_CLK_PERIOD_NS)
`define SRAM_RC_CYC `SRAM_CYC(`SRAM_T_RC_NS)
`define SRAM_A_CYC  `SRAM_CYC(`SRAM_T_A_NS)
`define SRAM_DF_CYC `SRAM_CYC(`SRAM_T_DF_NS)
`define SRAM_DS_CYC `SRAM_CYC(`SRAM_T_DS_NS)
`define SRAM_AW_CYC `SRAM_CYC(`SRAM_T_AW_NS)
`define SRAM_WP_CYC `SRAM_CYC(`SRAM_T_WP_NS)
`define SRAM_CW_CYC `SRAM_CYC(`SRAM_T_CW_NS)
`define SRAM_DH_CYC `SRAM_CYC(`SRAM_T_DH_NS)
`define SRAM_WR_CYC `SRAM_CYC(`SRAM_T_WR_NS)
// Extra cycles spent in the three-stage input synchroniser.
`define SRAM_SYNC_CYC 3

`endif

// ### design/sram_pin_sync.sv
// Three-stage synchroniser for the read data pins of the RAM.
// Assumes its inputs change asynchronously to clock.
`timescale 1ns/100ps
`default_nettype none

module sram_pin_sync #(
    parameter int W = 4
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] stage2,
    output logic      [W-1:0] stage3
);

    // The first stage feeds only the second, so a metastable value never reaches logic.
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
            end else begin
                s1_q <= pin[i];
                s2_q <= s1_q;
                s3_q <= s2_q;
            end
        end
        assign stage2[i] = s2_q;
        assign stage3[i] = s3_q;
    end

endmodule

`default_nettype wire

// ### dv/sram_host_assertions.sv
// Checker on the pins and handshakes of the static RAM host controller.
// Assumes it is bound to sram_host_ctrl and sees that module's ports.
`timescale 1ns/100ps
`default_nettype none

module sram_host_assertions #(
    parameter int ADDR_W    = 8,
    parameter int DATA_W    = 4,
    parameter bit SHARED_IO = 1'b0
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              rsp_valid,
    input wire logic              retain_ready,
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic              select_low_active_n,
    input wire logic              select_high_active,
    input wire logic              read_write,
    input wire logic [DATA_W-1:0] write_data_lines
);
    logic [7:0] sel_q, sel_d, low_q, low_d, off_q, off_d;
    wire        selected = !select_low_active_n && select_high_active;

    // The counters saturate, so a long standby never wraps below a bound.
    always_comb begin
        sel_d = selected ? sel_q + {7'h00, sel_q != 8'hff} : 8'h00;
        low_d = !read_write ? low_q + {7'h00, low_q != 8'hff} : 8'h00;
        off_d = (!select_high_active && !retain_ready) ? off_q + {7'h00, off_q != 8'hff} : 8'h00;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 8'h00;
            low_q <= 8'h00;
            off_q <= 8'h00;
        end else begin
            sel_q <= sel_d;
            low_q <= low_d;
            off_q <= off_d;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_idle_still: assert property (
        select_low_active_n && $past(select_low_active_n) |-> $stable(word_address)
        && $stable(read_write)) else $error("address or direction moved in standby");
    chk_retain_standby: assert property (
        retain_ready |-> !select_high_active && select_low_active_n)
        else $error("retention without forced standby");
    chk_write_selected: assert property (
        !read_write |-> selected) else $error("write pulse while unselected");
    chk_write_setup: assert property (
        $rose(read_write) |-> sel_q >= 8'h45) else $error("selects too short before write end");
    chk_pulse_width: assert property (
        $rose(read_write) |-> low_q >= 8'h32) else $error("write pulse too short");
    chk_write_data: assert property (
        !read_write || $rose(read_write) |-> $stable(write_data_lines) && $stable(word_address))
        else $error("data or address moved during write");
    chk_access_span: assert property (
        $rose(select_low_active_n) |-> sel_q >= 8'h52) else $error("access ended early");
    chk_rsp_release: assert property (
        rsp_valid |-> $rose(select_low_active_n) ##1 !rsp_valid)
        else $error("answer not tied to deselect");
    chk_resume_gap: assert property (
        $rose(select_high_active) |-> off_q >= 8'h52) else $error("resume gap too short");
endmodule

bind sram_host_ctrl sram_host_assertions #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W), .SHARED_IO(SHARED_IO)
) i_chk (
    .clock(clock), .rst_n(rst_n), .rsp_valid(rsp_valid), .retain_ready(retain_ready),
    .word_address(word_address), .select_low_active_n(select_low_active_n),
    .select_high_active(select_high_active), .read_write(read_write),
    .write_data_lines(write_data_lines)
);
`default_nettype wire

// ### dv/sram_model.sv
// Behavioural 256x4 static RAM on the host controller's pins.
// Assumes separate data lines; slow picks a long access time.
`timescale 1ns/100ps
`default_nettype none

module sram_model (
    input  wire logic [7:0] word_address,
    input  wire logic       select_low_active_n,
    input  wire logic       select_high_active,
    input  wire logic       read_write,
    input  wire logic       output_off,
    input  wire logic [3:0] write_data_lines,
    input  wire logic       slow,
    output logic      [3:0] read_data_lines
);
    logic [3:0] mem [256];
    realtime    t_chg;
    wire        sel = !select_low_active_n && select_high_active;
    wire        on  = sel && read_write && !output_off;

    initial read_data_lines = 4'h0;
    initial t_chg = 0.0;
    // A write lands on whichever ends first, the pulse or the select.
    always @(posedge read_write) if (sel) mem[word_address] = write_data_lines;
    always @(negedge sel) if (!read_write) mem[word_address] = write_data_lines;
    // Old data is spoilt at once, so an early sample cannot pass by luck.
    always @(word_address, sel, read_write, output_off) begin
        t_chg = $realtime;
        read_data_lines = ~read_data_lines;
    end
    always #2 if (on && $realtime - t_chg >= (slow ? 640.0 : 24.0))
        read_data_lines = mem[word_address];
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the static RAM host controller.
// Assumes the RAM model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic                 clock, rst_n, req_valid, req_ready, req_write;
    logic [7:0]           req_addr;
    logic [3:0]           req_wdata, rsp_rdata, rd_lines;
    logic                 rsp_valid, retain_req, retain_ready, slow;
    sram_host_pkg::pins_t pins;
    int                   bad_count, checks;

    sram_host_ctrl i_sram_host_ctrl (
        .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_req(retain_req),
        .retain_ready(retain_ready), .word_address(pins.word_address),
        .select_low_active_n(pins.select_low_active_n),
        .select_high_active(pins.select_high_active), .read_write(pins.read_write),
        .output_off(pins.output_off), .write_data_lines(pins.write_data_lines),
        .write_data_oe(pins.write_data_oe), .read_data_lines(rd_lines));
    sram_model i_sram_model (
        .word_address(pins.word_address), .select_low_active_n(pins.select_low_active_n),
        .select_high_active(pins.select_high_active), .read_write(pins.read_write),
        .output_off(pins.output_off), .write_data_lines(pins.write_data_lines),
        .slow(slow), .read_data_lines(rd_lines));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Polls at falling edges, where the design's outputs have settled.
    task automatic wait_for(input string what, ref logic sig, input int lim, output int n);
        n = 0;
        while (sig !== 1'b1) begin
            @(negedge clock);
            n++;
            if (n > lim) begin
                cmp(what, 8'h01, 8'h00);
                end_of_test;
            end
        end
    endtask

    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] d,
                          output logic [3:0] q);
        int n;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= a;
        req_wdata <= d;
        @(negedge clock);
        wait_for("req_ready", req_ready, 200, n);
        @(posedge clock);
        req_valid <= 1'b0;
        @(negedge clock);
        wait_for("rsp_valid", rsp_valid, 300, n);
        q = rsp_rdata;
    endtask

    task automatic check_reset;
        cmp("select_high_active", 8'h00, {7'h0, pins.select_high_active});
        cmp("select_low_active_n", 8'h01, {7'h0, pins.select_low_active_n});
        cmp("req_ready", 8'h00, {7'h0, req_ready});
        cmp("output_off", 8'h01, {7'h0, pins.output_off});
        cmp("write_data_oe", 8'h00, {7'h0, pins.write_data_oe});
    endtask

    task automatic write_read_table;
        logic [7:0] a [3] = '{8'h00, 8'hff, 8'h5a};
        logic [3:0] d [3] = '{4'ha, 4'h5, 4'h3};
        logic [3:0] q;
        foreach (a[i]) access(1'b1, a[i], d[i], q);
        foreach (a[i]) begin
            access(1'b0, a[i], 4'h0, q);
            cmp("read word", {4'h0, d[i]}, {4'h0, q});
        end
        access(1'b0, 8'hff, 4'h0, q);
        cmp("reread word", 8'h05, {4'h0, q});
    endtask

    task automatic slow_overwrite;
        logic [3:0] q;
        slow = 1'b1;
        access(1'b1, 8'h5a, 4'hc, q);
        access(1'b0, 8'h5a, 4'h0, q);
        cmp("slow read", 8'h0c, {4'h0, q});
        slow = 1'b0;
    endtask

    task automatic retention;
        logic [3:0] q;
        int n;
        @(posedge clock);
        retain_req <= 1'b1;
        @(negedge clock);
        wait_for("retain_ready", retain_ready, 20, n);
        cmp("select_high_active", 8'h00, {7'h0, pins.select_high_active});
        repeat (20) @(negedge clock);
        cmp("req_ready", 8'h00, {7'h0, req_ready});
        // With separate data lines the outputs stay enabled and the host still drives.
        cmp("output_off", 8'h00, {7'h0, pins.output_off});
        cmp("write_data_oe", 8'h01, {7'h0, pins.write_data_oe});
        @(posedge clock);
        retain_req <= 1'b0;
        @(negedge clock);
        wait_for("req_ready", req_ready, 200, n);
        cmp("resume gap", 8'h01, {7'h0, n >= 82});
        access(1'b0, 8'h00, 4'h0, q);
        cmp("retained word", 8'h0a, {4'h0, q});
    endtask

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 8'h00;
        req_wdata = 4'h0;
        retain_req = 1'b0;
        slow = 1'b0;
        bad_count = 0;
        checks = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(negedge clock);
        check_reset;
        write_read_table;
        slow_overwrite;
        retention;
        end_of_test;
    end
endmodule
`default_nettype wire
